// file: design/clk_ctrl_defs.vh
// Constants of the system clock control block: register offsets, field
// positions, reset values and timing counts.
// Assumes a 100 MHz master clock and 32-bit Avalon-MM byte addressing.
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

`define PRESCALE_CTRL_INDEX 8'h61
`define RC_TRIM_INDEX 8'h66
`define CLK_STATUS_INDEX 8'h70
`define CLK_STATUS_ADDR 10'h01C0
`define PRESCALE_CTRL_ADDR 10'h0184
`define RC_TRIM_ADDR 10'h0198
`define TIMER_ASYNC_ADDR 10'h01C4

`define PCE_BIT 7
`define PSEL_MSB 3
`define PSEL_LSB 0
`define PSEL_RESET_DIV8 4'h3
`define PSEL_RESET_NODIV 4'h0
`define PSEL_MAX 4'h8
`define PCE_WINDOW 3'h4
`define PCE_WRITE_VALUE 8'h80

`define SRC_EXT_CLOCK 4'h0
`define SRC_RC_OSC 4'h2

`define SUT_FAST 2'h0
`define SUT_MEDIUM 2'h1
`define SUT_SLOW 2'h2
`define SLEEP_WAKE_CK 16'h0006
`define RESET_BASE_CK 16'h000E
`define DELAY_MEDIUM_US 4100
`define DELAY_SLOW_US 65000
`define CLK_MHZ 100
`define PIN_IDLE_LIMIT 16'hFFFF

`endif

// file: design/clock_control.v
// System clock control: source selection, start-up delay, prescaler,
// clock output and RC oscillator trim, with an Avalon-MM register slave.
// Assumes fuse inputs are static and the master clock runs undivided.
//
// Summary of operation
// - Fuse code 0000 selects the external clock.
// - Start-up time fuses set the reset delay; the wake delay is fixed.
// - Timer oscillator only with RC clock selected and active prescaler select 0 or 1.
// - Enable bit lets timer pin take clock.
// - Output fuse drives system clock, even in reset.
// - Clock output carries the divided clock.
// - Prescaler divides io, core and memory clocks.
// - No glitches or overfast clocks while switching.
// - New rate after one old, one-two new periods.
// - Enable bit updates only with other bits zero.
// - Enable clears after four cycles or selection write.
// - Rewriting enable neither restarts nor clears window.
// - Reset selection is 0011 with divide fuse.
// - Any selection value may be written.
// - Codes 0-8 divide by powers of two.
// - Reset loads factory calibration into trim register.
// - Top trim bit picks low or high range.
// - Lower seven bits tune within the range.
// - Fuse code 0010 selects the internal RC oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defs.vh"
module clock_control #(
  parameter [7:0] FACTORY_TRIM = 8'h80,
  parameter DELAY_MEDIUM_CK = `DELAY_MEDIUM_US * `CLK_MHZ,
  parameter DELAY_SLOW_CK = `DELAY_SLOW_US * `CLK_MHZ
) (
  input wire mclk,
  input wire nrst,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire [3:0] clock_source_select_fuses,
  input wire [1:0] startup_time_fuses,
  input wire clock_output_fuse,
  input wire divide_by_eight_fuse,
  input wire wake_request,
  input wire external_clock_input,
  input wire timer_osc_pin_one,
  output reg core_clock_en_q,
  output reg peripheral_io_clock_en_q,
  output reg program_memory_clock_en_q,
  output reg clock_output_pin,
  output reg clock_output_oe,
  output reg chip_ready_q,
  output reg use_external_clock_q,
  output reg use_rc_osc_q,
  output reg timer_osc_enable_q,
  output reg timer_clock_sample_q,
  output reg [7:0] rc_oscillator_trim_q,
  output reg [3:0] active_select_q
);
  reg rst_s1_q;
  reg rst_n;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Three-stage pin synchroniser; a change counts when stages two and three agree.
  reg [2:0] ext_sync_q;
  reg [2:0] tosc_sync_q;
  reg ext_clk_q;
  reg tosc_clk_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_q <= 3'h0;
      tosc_sync_q <= 3'h0;
      ext_clk_q <= 1'b0;
      tosc_clk_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_clock_input};
      tosc_sync_q <= {tosc_sync_q[1:0], timer_osc_pin_one};
      if (ext_sync_q[1] == ext_sync_q[2])
        ext_clk_q <= ext_sync_q[2];
      if (tosc_sync_q[1] == tosc_sync_q[2])
        tosc_clk_q <= tosc_sync_q[2];
    end
  end

  // Neither pin clocks any logic here, since the master clock already is the
  // system clock; a source that stops shows in the status word instead.
  // A source slower than about 760 Hz reads as stopped.
  reg ext_clk_d1_q;
  reg tosc_clk_d1_q;
  reg [15:0] ext_idle_q;
  reg [15:0] tosc_idle_q;
  reg ext_alive_q;
  reg tosc_alive_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_d1_q <= 1'b0;
      tosc_clk_d1_q <= 1'b0;
      ext_idle_q <= 16'h0000;
      tosc_idle_q <= 16'h0000;
      ext_alive_q <= 1'b0;
      tosc_alive_q <= 1'b0;
    end else begin
      ext_clk_d1_q <= ext_clk_q;
      tosc_clk_d1_q <= tosc_clk_q;
      if (ext_clk_q != ext_clk_d1_q) begin
        ext_idle_q <= 16'h0000;
        ext_alive_q <= 1'b1;
      end else if (ext_idle_q == `PIN_IDLE_LIMIT) begin
        ext_alive_q <= 1'b0;
      end else begin
        ext_idle_q <= ext_idle_q + 16'h0001;
      end
      if (tosc_clk_q != tosc_clk_d1_q) begin
        tosc_idle_q <= 16'h0000;
        tosc_alive_q <= 1'b1;
      end else if (tosc_idle_q == `PIN_IDLE_LIMIT) begin
        tosc_alive_q <= 1'b0;
      end else begin
        tosc_idle_q <= tosc_idle_q + 16'h0001;
      end
    end
  end

  // Straps are caught on the first clock after reset release.
  reg fuses_taken_q;
  reg [3:0] src_q;
  reg [1:0] sut_q;
  reg clock_output_fuse_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fuses_taken_q <= 1'b0;
      src_q <= `SRC_RC_OSC;
      sut_q <= `SUT_FAST;
      clock_output_fuse_q <= 1'b0;
    end else if (!fuses_taken_q) begin
      fuses_taken_q <= 1'b1;
      src_q <= clock_source_select_fuses;
      sut_q <= startup_time_fuses;
      clock_output_fuse_q <= clock_output_fuse;
    end
  end

  // Start-up delay: reset base count plus the fuse-selected extra.
  localparam ST_LOAD = 3'b001;
  localparam ST_COUNT = 3'b010;
  localparam ST_RUN = 3'b100;
  reg [2:0] st_q;
  reg [31:0] delay_q;
  reg [3:0] sel_q;
  reg pce_q;
  reg [2:0] pce_cnt_q;
  reg timer_ext_en_q;
  wire [31:0] extra_w = (sut_q == `SUT_MEDIUM) ? DELAY_MEDIUM_CK :
                        (sut_q == `SUT_SLOW) ? DELAY_SLOW_CK : 32'h0000_0000;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_LOAD;
      delay_q <= 32'h0000_0000;
      chip_ready_q <= 1'b0;
    end else begin
      case (st_q)
        ST_LOAD: begin
          if (fuses_taken_q) begin
            delay_q <= {16'h0000, `RESET_BASE_CK} + extra_w;
            st_q <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (delay_q <= 32'h0000_0001) begin
            chip_ready_q <= 1'b1;
            st_q <= ST_RUN;
          end else begin
            delay_q <= delay_q - 32'h0000_0001;
          end
        end
        ST_RUN: begin
          if (wake_request && chip_ready_q) begin
            // A wake from a deep sleep stalls the core for the short count.
            chip_ready_q <= 1'b0;
            delay_q <= {16'h0000, `SLEEP_WAKE_CK};
            st_q <= ST_COUNT;
          end
        end
        default: st_q <= ST_LOAD;
      endcase
    end
  end

  wire tick_w;
  wire [3:0] act_w;
  glitchfree_divider #(.CW(8)) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .sel(sel_q),
    .tick_q(tick_w),
    .active_sel_q(act_w)
  );

  // Bus decode; each access answers after one wait cycle.
  wire hit_pce_w = (avs_address == `PRESCALE_CTRL_ADDR);
  wire hit_trim_w = (avs_address == `RC_TRIM_ADDR);
  wire hit_stat_w = (avs_address == `CLK_STATUS_ADDR);
  wire hit_tim_w = (avs_address == `TIMER_ASYNC_ADDR);
  reg done_q;
  wire req_w = (avs_read || avs_write) && avs_waitrequest && !done_q;
  wire wr_w = avs_write && req_w && avs_byteenable[0];
  wire [7:0] wd_w = avs_writedata[7:0];
  wire pce_wr_w = wr_w && hit_pce_w && (wd_w == `PCE_WRITE_VALUE);
  wire psel_wr_w = wr_w && hit_pce_w && !wd_w[`PCE_BIT];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= `PSEL_RESET_NODIV;
      pce_q <= 1'b0;
      pce_cnt_q <= 3'h0;
      rc_oscillator_trim_q <= 8'h00;
      timer_ext_en_q <= 1'b0;
    end else begin
      if (!fuses_taken_q) begin
        sel_q <= divide_by_eight_fuse ? `PSEL_RESET_DIV8 : `PSEL_RESET_NODIV;
        rc_oscillator_trim_q <= FACTORY_TRIM;
      end else begin
        if (psel_wr_w && pce_q) begin
          sel_q <= wd_w[`PSEL_MSB:`PSEL_LSB];
          pce_q <= 1'b0;
        end else if (pce_wr_w && !pce_q) begin
          pce_q <= 1'b1;
          pce_cnt_q <= `PCE_WINDOW;
        end else if (pce_q) begin
          // A repeated enable write falls here and the count keeps running down.
          if (pce_cnt_q <= 3'h1)
            pce_q <= 1'b0;
          pce_cnt_q <= pce_cnt_q - 3'h1;
        end
        // Selection writes with the window closed drop out above.
        if (wr_w && hit_trim_w)
          rc_oscillator_trim_q <= wd_w;
        if (wr_w && hit_tim_w)
          timer_ext_en_q <= wd_w[0];
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
      done_q <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
      done_q <= 1'b0;
      if (req_w) begin
        avs_waitrequest <= 1'b0;
        done_q <= 1'b1;
        avs_response <= (hit_pce_w || hit_trim_w || hit_stat_w || hit_tim_w) ? 2'h0 : 2'h2;
        if (avs_read) begin
          if (hit_pce_w)
            avs_readdata <= {24'h00_0000, pce_q, 3'h0, sel_q};
          else if (hit_trim_w)
            avs_readdata <= {24'h00_0000, rc_oscillator_trim_q};
          else if (hit_stat_w)
            avs_readdata <= {16'h0000, act_w, src_q, 2'h0, sut_q, tosc_alive_q, ext_alive_q, clock_output_fuse_q, chip_ready_q};
          else if (hit_tim_w)
            avs_readdata <= {31'h0000_0000, timer_ext_en_q};
          else
            avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Clock enables and the output pin.
  reg clock_output_pin_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_clock_en_q <= 1'b0;
      peripheral_io_clock_en_q <= 1'b0;
      program_memory_clock_en_q <= 1'b0;
      clock_output_pin_q <= 1'b0;
      use_external_clock_q <= 1'b0;
      use_rc_osc_q <= 1'b0;
      timer_osc_enable_q <= 1'b0;
      timer_clock_sample_q <= 1'b0;
      active_select_q <= 4'h0;
    end else begin
      core_clock_en_q <= tick_w && chip_ready_q;
      peripheral_io_clock_en_q <= tick_w && chip_ready_q;
      program_memory_clock_en_q <= tick_w && chip_ready_q;
      active_select_q <= act_w;
      if (tick_w)
        clock_output_pin_q <= ~clock_output_pin_q;
      use_external_clock_q <= fuses_taken_q && (src_q == `SRC_EXT_CLOCK);
      use_rc_osc_q <= fuses_taken_q && (src_q == `SRC_RC_OSC);
      timer_osc_enable_q <= fuses_taken_q && (src_q == `SRC_RC_OSC) && (act_w <= 4'h1);
      timer_clock_sample_q <= timer_ext_en_q ? tosc_clk_q : 1'b0;
    end
  end

  // The pin register has no reset at all so the clock keeps going.
  // No reset may stop this toggle, so it is given a start value instead.
  reg clock_output_pin_free_q = 1'b0;
  always @(posedge mclk) begin
    clock_output_pin_free_q <= ~clock_output_pin_free_q;
    clock_output_pin <= rst_n ? clock_output_pin_q : clock_output_pin_free_q;
    clock_output_oe <= rst_n ? clock_output_fuse_q : clock_output_fuse;
  end
endmodule
`default_nettype wire

// file: design/glitchfree_divider.v
// Glitch-free power-of-two clock divider producing a one-cycle enable tick.
// Assumes the select input is stable except when the owner hands a new one.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defs.vh"
module glitchfree_divider #(
  parameter CW = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] sel,
  output reg tick_q,
  output reg [3:0] active_sel_q
);
  reg [CW-1:0] cnt_q;
  reg [3:0] pend_q;
  reg pend_v_q;

  function [CW-1:0] div_mask;
    input [3:0] s;
    begin
      div_mask = (s > `PSEL_MAX) ? {CW{1'b0}} : ((({{(CW-1){1'b0}}, 1'b1}) << s) - {{(CW-1){1'b0}}, 1'b1});
    end
  endfunction

  wire last_w = ((cnt_q & div_mask(active_sel_q)) == div_mask(active_sel_q));

  // Switching only at the end of an old period means no short pulse appears.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {CW{1'b0}};
      tick_q <= 1'b0;
      pend_q <= 4'h0;
      pend_v_q <= 1'b0;
      active_sel_q <= 4'h0;
    end else begin
      tick_q <= last_w;
      if (sel != active_sel_q && !pend_v_q) begin
        pend_q <= sel;
        pend_v_q <= 1'b1;
      end
      if (last_w) begin
        cnt_q <= {CW{1'b0}};
        if (pend_v_q) begin
          active_sel_q <= pend_q;
          pend_v_q <= 1'b0;
        end
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/clk_ctrl_checker.sv
// Assertion checker for the clock control block, bound to its top module.
// Assumes the fuse straps change only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_checker #(
  parameter [7:0] FACTORY_TRIM = 8'h80
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic clock_output_fuse,
  input wire logic divide_by_eight_fuse,
  input wire logic core_clock_en_q,
  input wire logic peripheral_io_clock_en_q,
  input wire logic program_memory_clock_en_q,
  input wire logic clock_output_pin,
  input wire logic clock_output_oe,
  input wire logic chip_ready_q,
  input wire logic use_external_clock_q,
  input wire logic use_rc_osc_q,
  input wire logic timer_osc_enable_q,
  input wire logic [7:0] rc_oscillator_trim_q,
  input wire logic [3:0] active_select_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Reserved codes divide by one, so only codes 1 to 8 count as slowed.
  wire slow = active_select_q != 4'h0 && active_select_q <= 4'h8;
  AST_OE: assert property (chip_ready_q |-> clock_output_oe == clock_output_fuse)
    else $error("clock output enable differs from fuse");
  AST_EXT: assert property (chip_ready_q |-> use_external_clock_q == (clock_source_select_fuses == 4'h0))
    else $error("external source flag wrong");
  AST_RC: assert property (chip_ready_q |-> use_rc_osc_q == (clock_source_select_fuses == 4'h2))
    else $error("rc source flag wrong");
  AST_TOSC: assert property (timer_osc_enable_q |-> use_rc_osc_q)
    else $error("timer oscillator on without rc source");
  AST_ENS: assert property (core_clock_en_q == peripheral_io_clock_en_q && core_clock_en_q == program_memory_clock_en_q)
    else $error("divided clock enables disagree");
  AST_SLOW: assert property ((core_clock_en_q && slow) ##1 slow |-> !core_clock_en_q)
    else $error("divided clock faster than selected");
  // The select flag lags the divider by a cycle, so the toggle that ends a fast setting is let pass.
  AST_CLOCK_OUTPUT_PIN: assert property (($changed(clock_output_pin) && slow && $past(slow) && chip_ready_q) ##1 slow
    |-> $stable(clock_output_pin))
    else $error("clock output not divided");
  AST_TRIM: assert property ($rose(chip_ready_q) |-> rc_oscillator_trim_q == FACTORY_TRIM)
    else $error("trim not loaded at reset");
  AST_SEL: assert property ($rose(chip_ready_q) |-> active_select_q == (divide_by_eight_fuse ? 4'h3 : 4'h0))
    else $error("reset division wrong");
  cover property (chip_ready_q && slow && core_clock_en_q);
  cover property ($rose(chip_ready_q) && use_external_clock_q);
  cover property (timer_osc_enable_q);
endmodule
bind clock_control clk_ctrl_checker #(.FACTORY_TRIM(FACTORY_TRIM)) u_clk_ctrl_checker (.mclk, .nrst,
  .clock_source_select_fuses, .clock_output_fuse, .divide_by_eight_fuse, .core_clock_en_q, .peripheral_io_clock_en_q,
  .program_memory_clock_en_q, .clock_output_pin, .clock_output_oe, .chip_ready_q, .use_external_clock_q,
  .use_rc_osc_q, .timer_osc_enable_q, .rc_oscillator_trim_q, .active_select_q);
`default_nettype wire

// file: verif/ext_clock_source.sv
// Model of the board clocks that feed the external clock and timer pins.
// Assumes both run free; the block synchronises them itself.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
  output var logic external_clock_input,
  output var logic timer_osc_pin_one
);
  initial begin
    external_clock_input = 1'b0;
    timer_osc_pin_one = 1'b0;
  end
  // A steady 20 MHz source never varies between cycles.
  always #25 external_clock_input = ~external_clock_input;
  always #80 timer_osc_pin_one = ~timer_osc_pin_one;
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking testbench of the clock control block.
// Assumes the clock source model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] TRIM = 8'h5A;
  logic mclk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, wake_request = 1'b0;
  logic divide_by_eight_fuse = 1'b1, clock_output_fuse = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0] avs_byteenable = 4'h1, clock_source_select_fuses = 4'h2, active_select_q;
  logic [1:0] startup_time_fuses = 2'h0, avs_response;
  logic [7:0] rc_oscillator_trim_q, rd;
  logic avs_waitrequest, external_clock_input, timer_osc_pin_one, core_clock_en_q, clock_output_pin;
  logic clock_output_oe, chip_ready_q, use_external_clock_q, use_rc_osc_q, timer_osc_enable_q;
  logic timer_clock_sample_q, prev_t;
  int fails = 0, samples_checked = 0, cycles = 0, t0, t1, p, tk;
  int rows[11][2] = '{'{8, 256}, '{0, 1}, '{3, 8}, '{1, 2}, '{9, 1}, '{2, 4}, '{4, 16}, '{5, 32}, '{6, 64},
    '{7, 128}, '{15, 1}};
  clock_control #(.FACTORY_TRIM(TRIM), .DELAY_MEDIUM_CK(20), .DELAY_SLOW_CK(40)) u_clock_control (
    .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .clock_source_select_fuses, .startup_time_fuses, .clock_output_fuse,
    .divide_by_eight_fuse, .wake_request, .external_clock_input, .timer_osc_pin_one, .core_clock_en_q,
    .peripheral_io_clock_en_q(), .program_memory_clock_en_q(), .clock_output_pin, .clock_output_oe,
    .chip_ready_q, .use_external_clock_q, .use_rc_osc_q, .timer_osc_enable_q, .timer_clock_sample_q,
    .rc_oscillator_trim_q, .active_select_q);
  ext_clock_source u_ext_clock_source (.external_clock_input, .timer_osc_pin_one);
  always #5 mclk = ~mclk;
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n == 40) fails++;
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge keeps a following call from driving the strobe twice in one step.
    @(posedge mclk);
  endtask
  task automatic set_div(input logic [7:0] v);
    bus(1'b1, 10'h184, 8'h80);
    bus(1'b1, 10'h184, v);
  endtask
  task automatic measure(output int q);
    int n = 0;
    q = 1;
    while (core_clock_en_q !== 1'b1 && n < 600) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    while (core_clock_en_q !== 1'b1 && q < 600) begin
      @(posedge mclk);
      q++;
    end
  endtask
  task automatic do_reset(input logic d8, input logic [3:0] s, input logic [1:0] su, output int t);
    int k = 0;
    logic prev;
    divide_by_eight_fuse <= d8;
    clock_source_select_fuses <= s;
    startup_time_fuses <= su;
    nrst <= 1'b0;
    repeat (9) @(posedge mclk);
    prev = clock_output_pin;
    repeat (7) begin
      @(posedge mclk);
      k += (clock_output_pin !== prev);
      prev = clock_output_pin;
    end
    check(k, 7);
    check(clock_output_oe, 1'b1);
    nrst <= 1'b1;
    t = 0;
    while (chip_ready_q !== 1'b1 && t < 300) begin
      @(posedge mclk);
      t++;
    end
    check(rc_oscillator_trim_q, TRIM);
    check(active_select_q, d8 ? 4'h3 : 4'h0);
    check(use_external_clock_q, s == 4'h0);
    check(use_rc_osc_q, s == 4'h2);
  endtask
  initial begin
    do_reset(1'b1, 4'h2, 2'h0, t0);
    bus(1'b0, 10'h198, 8'h00);
    check(rd, TRIM);
    bus(1'b1, 10'h198, 8'h7F);
    bus(1'b0, 10'h198, 8'h00);
    check(rd, 8'h7F);
    check(rc_oscillator_trim_q, 8'h7F);
    bus(1'b0, 10'h3F0, 8'h00);
    check(avs_response, 2'h2);
    foreach (rows[i]) begin
      set_div(8'(rows[i][0]));
      bus(1'b0, 10'h184, 8'h00);
      check(rd, rows[i][0]);
      // Longest switch is one old and two new periods of at most 256 cycles each.
      repeat (800) @(posedge mclk);
      measure(p);
      check(p, rows[i][1]);
    end
    set_div(8'h01);
    check(timer_clock_sample_q, 1'b0);
    bus(1'b1, 10'h1C4, 8'h01);
    tk = 0;
    prev_t = timer_clock_sample_q;
    repeat (32) begin
      @(posedge mclk);
      tk += (timer_clock_sample_q !== prev_t);
      prev_t = timer_clock_sample_q;
    end
    check(tk, 4);
    bus(1'b1, 10'h184, 8'h80);
    bus(1'b0, 10'h184, 8'h00);
    check(rd, 8'h81);
    bus(1'b1, 10'h184, 8'h80);
    bus(1'b1, 10'h184, 8'h80);
    bus(1'b0, 10'h184, 8'h00);
    check(rd, 8'h01);
    bus(1'b1, 10'h184, 8'h04);
    bus(1'b1, 10'h184, 8'h81);
    bus(1'b1, 10'h184, 8'h04);
    bus(1'b1, 10'h184, 8'h80);
    repeat (6) @(posedge mclk);
    bus(1'b1, 10'h184, 8'h04);
    bus(1'b0, 10'h184, 8'h00);
    check(rd, 8'h01);
    measure(p);
    check(p, 2);
    do_reset(1'b0, 4'h0, 2'h1, t1);
    check(t1 - t0, 20);
    measure(p);
    check(p, 1);
    bus(1'b0, 10'h1C0, 8'h00);
    check(rd, 8'h1F);
    wake_request <= 1'b1;
    @(posedge mclk);
    wake_request <= 1'b0;
    p = 0;
    @(posedge mclk);
    while (chip_ready_q !== 1'b1 && p < 50) begin
      @(posedge mclk);
      p++;
    end
    check(p, 6);
    give_verdict();
  end
endmodule
`default_nettype wire
